//--- rtl/vgio_pkg.sv
// constants for the a16 general purpose io slave
// assumes a 20 MHz local clock and backplane inputs synchronous to it
package vgio_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus widths and codes
    localparam int DATA_W = 16;
    localparam int OFF_W = 8;
    localparam int IDX_W = 3;
    localparam int NUM_GP = 4;
    localparam logic [5:0] AM_A16_NPRIV = 6'h29;
    localparam logic [5:0] AM_A16_SUPER = 6'h2d;
    localparam logic [OFF_W-1:0] OFF_ALL_ONES = 8'hff;
    localparam logic [OFF_W-1:0] OFF_CAPTURE_RST = 8'hff;

    // address line positions
    localparam int ADDR_HI = 15;
    localparam int ADDR_HI2 = 14;
    localparam int LA_MSB = 13;
    localparam int LA_LSB = 6;
    localparam int IDX_MSB = 3;
    localparam int IDX_LSB = 1;

    ////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [IDX_W-1:0] IDX_IDENTITY = 3'h0;
    localparam logic [IDX_W-1:0] IDX_DEVTYPE = 3'h1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 3'h2;
    localparam logic [IDX_W-1:0] IDX_OFFSET = 3'h3;
    localparam logic [IDX_W-1:0] IDX_GP_BASE = 3'h4;

    // identity word fields
    localparam logic [1:0] ID_CLASS_REGBASED = 2'h3;
    localparam logic [1:0] ID_ADDR_A16_ONLY = 2'h3;
    localparam logic [11:0] MAKER_CODE_DEF = 12'h5a3; // arbitrary value

    // status read bit positions, spares read one
    localparam int ST_MODID_N = 0;
    localparam int ST_AUX_READY = 2;
    localparam int ST_AUX_PASS = 3;
    localparam int ST_PWR_OK_N = 6;
    localparam int ST_PWR_FAIL_N = 7;
    localparam int ST_EE_DOUT = 8;
    localparam logic [DATA_W-1:0] ST_SPARE_ONES = 16'hffff;

    // status write bit positions
    localparam int SW_EE_DIN = 0;
    localparam int SW_EE_CLK = 1;
    localparam int SW_EE_CS = 2;
    localparam int SW_SOFT_RST_N = 3;

    // offset readback upper byte
    localparam logic [OFF_W-1:0] OFF_RB_HIGH = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // activity stretch time
    localparam int CLK_HZ = 20000000;
    localparam int ACT_STRETCH_MS = 50;
    localparam int ACT_CYCLES = CLK_HZ / 1000 * ACT_STRETCH_MS;
    localparam int ACT_CNT_W = 20;
    localparam int NUM_SUPPLIES = 5;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } vgio_state_type;

endpackage

//--- rtl/vgio_a16_slave.sv
// a16 register based general purpose io card logic
// assumes backplane strobes already synchronous to ref_clk, one access at a time
`timescale 1ns/100ps
module vgio_a16_slave #(
    parameter int ACT_STRETCH_CYCLES = vgio_pkg::ACT_CYCLES, // visible pulse length
    parameter logic [11:0] MAKER_CODE = vgio_pkg::MAKER_CODE_DEF // arbitrary value
) (
    input wire logic ref_clk, // local clock
    input wire logic rstn, // async reset, active low
    input wire logic as_n, // address strobe
    input wire logic ds_n, // data strobe
    input wire logic write_n, // low for write
    input wire logic lword_n, // longword indicator
    input wire logic [5:0] am, // address modifier
    input wire logic [15:1] addr, // address lines
    input wire logic modid_n, // module identification line
    input wire logic [vgio_pkg::DATA_W-1:0] data_in, // backplane data in
    output logic [vgio_pkg::DATA_W-1:0] data_out, // backplane data out
    output logic data_oe, // drive data lines
    output logic buf_en, // data buffers enabled
    output logic dtack_n, // transfer acknowledge
    input wire logic [vgio_pkg::OFF_W-1:0] offset_switch_bank, // up is one
    input wire logic [7:0] devtype_high_switches, // up is one
    input wire logic [7:0] devtype_low_switches, // up is one
    input wire logic [vgio_pkg::NUM_SUPPLIES-1:0] supply_in_tol, // comparators
    input wire logic aux_ready_flag, // aux connector, high when open
    input wire logic aux_selftest_pass_flag, // aux connector, high when open
    input wire logic eeprom_dout, // serial eeprom data out
    input wire logic eeprom_prog_strap, // strap low inhibits programming
    output logic eeprom_din, // serial eeprom data in
    output logic eeprom_clk, // serial eeprom clock
    output logic eeprom_cs, // serial eeprom select
    output logic eeprom_prog_en, // program enable
    output logic soft_reset_out_n, // to aux connector
    output logic power_ok_n, // green indicator
    output logic power_fail_n, // red indicator
    output logic activity_led, // yellow indicator
    input wire logic [vgio_pkg::DATA_W-1:0] gp_in_a, // connector a read
    input wire logic [vgio_pkg::DATA_W-1:0] gp_in_b, // connector b read
    input wire logic [vgio_pkg::DATA_W-1:0] gp_in_c, // connector c read
    input wire logic [vgio_pkg::DATA_W-1:0] gp_in_d, // connector d read
    output logic [vgio_pkg::DATA_W-1:0] gp_out_a, // connector a latch
    output logic [vgio_pkg::DATA_W-1:0] gp_out_b, // connector b latch
    output logic [vgio_pkg::DATA_W-1:0] gp_out_c, // connector c latch
    output logic [vgio_pkg::DATA_W-1:0] gp_out_d // connector d latch
);
    import vgio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    vgio_state_type state_q, state_d;
    logic [OFF_W-1:0] capture_q;
    logic [OFF_W-1:0] active_off_q;
    logic [OFF_W-1:0] active_off;
    logic [DATA_W-1:0] data_out_q;
    logic data_oe_q;
    logic buf_en_q;
    logic dtack_n_q;
    logic ee_din_q, ee_clk_q, ee_cs_q, ee_prog_q, soft_rst_n_q;
    logic pwr_ok_n_q, pwr_fail_n_q;
    logic [ACT_CNT_W-1:0] act_cnt_q;
    logic act_led_q;
    logic [DATA_W-1:0] gp_q [NUM_GP];
    logic [DATA_W-1:0] gp_rd [NUM_GP];
    logic am_ok, card_sel, grant, grant_wr, grant_rd;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // offset source
    // switch or capture latch
    assign active_off = (offset_switch_bank == OFF_ALL_ONES) ? capture_q : offset_switch_bank;

    // registered copy of the active offset, used only by a_offset_switch; readback takes active_off
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            active_off_q <= OFF_CAPTURE_RST;
        end else begin
            active_off_q <= active_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // card selection
    // short space modifiers only
    assign am_ok = (am == AM_A16_NPRIV) || (am == AM_A16_SUPER);
    assign card_sel = am_ok && addr[ADDR_HI] && addr[ADDR_HI2] && lword_n
                      && (addr[LA_MSB:LA_LSB] == active_off);
    assign grant = (state_q == ST_IDLE) && !as_n && !ds_n && card_sel;
    assign grant_wr = grant && !write_n;
    assign grant_rd = grant && write_n;
    assign idx = addr[IDX_MSB:IDX_LSB];

    ////////////////////////////////////////////////////////////////////////
    // read data sources
    assign gp_rd[0] = gp_in_a;
    assign gp_rd[1] = gp_in_b;
    assign gp_rd[2] = gp_in_c;
    assign gp_rd[3] = gp_in_d;

    always_comb begin
        status_word = ST_SPARE_ONES;
        status_word[ST_MODID_N] = modid_n;
        status_word[ST_AUX_READY] = aux_ready_flag;
        status_word[ST_AUX_PASS] = aux_selftest_pass_flag;
        status_word[ST_PWR_OK_N] = pwr_ok_n_q;
        status_word[ST_PWR_FAIL_N] = pwr_fail_n_q;
        status_word[ST_EE_DOUT] = eeprom_dout;
    end

    // read multiplexer over the eight selects
    always_comb begin
        case (idx)
            IDX_IDENTITY: rd_word = {ID_CLASS_REGBASED, ID_ADDR_A16_ONLY, MAKER_CODE};
            IDX_DEVTYPE: rd_word = ~{devtype_high_switches, devtype_low_switches};
            IDX_STATUS: rd_word = status_word;
            IDX_OFFSET: rd_word = {OFF_RB_HIGH, active_off};
            default: rd_word = gp_rd[2'(idx - IDX_GP_BASE)];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // access state machine
    // acknowledge only, no interrupt lines
    always_comb begin
        case (state_q)
            ST_IDLE: state_d = grant ? ST_HOLD : ST_IDLE;
            ST_HOLD: state_d = ds_n ? ST_IDLE : ST_HOLD;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // acknowledge and data drive
    // buffers only while accessed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dtack_n_q <= 1'b1;
            buf_en_q <= 1'b0;
            data_oe_q <= 1'b0;
            data_out_q <= '0;
        end else if (grant) begin
            dtack_n_q <= 1'b0;
            buf_en_q <= 1'b1;
            data_oe_q <= write_n;
            data_out_q <= write_n ? rd_word : data_out_q;
        end else if (state_q == ST_HOLD && ds_n) begin
            dtack_n_q <= 1'b1;
            buf_en_q <= 1'b0;
            data_oe_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // identification capture
    // low byte while modid and switches ff
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            capture_q <= OFF_CAPTURE_RST;
        end else if (grant_wr && idx == IDX_OFFSET && !modid_n && offset_switch_bank == OFF_ALL_ONES) begin
            capture_q <= data_in[OFF_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status write
    // eeprom control and soft reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ee_din_q <= 1'b0;
            ee_clk_q <= 1'b0;
            ee_cs_q <= 1'b0;
            soft_rst_n_q <= 1'b1;
        end else if (grant_wr && idx == IDX_STATUS) begin
            ee_din_q <= data_in[SW_EE_DIN];
            ee_clk_q <= data_in[SW_EE_CLK];
            ee_cs_q <= data_in[SW_EE_CS];
            soft_rst_n_q <= data_in[SW_SOFT_RST_N];
        end
    end

    // program enable defaults high, strap may pull low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ee_prog_q <= 1'b1;
        end else begin
            ee_prog_q <= eeprom_prog_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // supply monitor
    // good only when all in tolerance
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_ok_n_q <= 1'b1;
            pwr_fail_n_q <= 1'b0;
        end else begin
            pwr_ok_n_q <= ~(&supply_in_tol);
            pwr_fail_n_q <= &supply_in_tol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general purpose write latches
    // write latch separate from read path
    for (genvar g = 0; g < NUM_GP; g++) begin : g_gp
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                gp_q[g] <= '0;
            end else if (grant_wr && idx == IDX_W'(IDX_GP_BASE + IDX_W'(g))) begin
                gp_q[g] <= data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activity stretcher
    // reload on every access
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            act_cnt_q <= '0;
            act_led_q <= 1'b0;
        end else if (grant) begin
            act_cnt_q <= ACT_CNT_W'(ACT_STRETCH_CYCLES);
            act_led_q <= 1'b1;
        end else if (act_cnt_q != '0) begin
            act_cnt_q <= act_cnt_q - 1'b1;
            act_led_q <= (act_cnt_q != ACT_CNT_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign buf_en = buf_en_q;
    assign dtack_n = dtack_n_q;
    assign eeprom_din = ee_din_q;
    assign eeprom_clk = ee_clk_q;
    assign eeprom_cs = ee_cs_q;
    assign eeprom_prog_en = ee_prog_q;
    assign soft_reset_out_n = soft_rst_n_q;
    assign power_ok_n = pwr_ok_n_q;
    assign power_fail_n = pwr_fail_n_q;
    assign activity_led = act_led_q;
    assign gp_out_a = gp_q[0];
    assign gp_out_b = gp_q[1];
    assign gp_out_c = gp_q[2];
    assign gp_out_d = gp_q[3];

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_am_decode: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(dtack_n_q) |-> $past(am == AM_A16_NPRIV || am == AM_A16_SUPER))
        else $error("acknowledge with illegal address modifier");

    a_addr_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(dtack_n_q) |-> $past(addr[ADDR_HI] && addr[ADDR_HI2]))
        else $error("acknowledge without high address lines");

    a_lword_word: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(dtack_n_q) |-> $past(lword_n))
        else $error("acknowledge on longword transfer");

    a_offset_switch: assert property (@(posedge ref_clk) disable iff (!rstn)
        (offset_switch_bank != OFF_ALL_ONES) |=> active_off_q == $past(offset_switch_bank))
        else $error("switch offset not used");

    a_modid_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        (grant_wr && idx == IDX_OFFSET && !modid_n && offset_switch_bank == OFF_ALL_ONES)
        |=> capture_q == $past(data_in[OFF_W-1:0]))
        else $error("identification byte not captured");

    a_buffer_access: assert property (@(posedge ref_clk) disable iff (!rstn)
        data_oe_q |-> (buf_en_q && !dtack_n_q))
        else $error("data driven outside an access");

    a_buffer_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        buf_en_q && $past(buf_en_q) |-> $past(!ds_n))
        else $error("buffers held after data strobe release");

    a_status_supply: assert property (@(posedge ref_clk) disable iff (!rstn)
        grant_rd && idx == IDX_STATUS |=> data_out_q[ST_PWR_OK_N] == $past(pwr_ok_n_q)
        && data_out_q[ST_EE_DOUT] == $past(eeprom_dout))
        else $error("status read wrong");

    a_offset_rb: assert property (@(posedge ref_clk) disable iff (!rstn)
        grant_rd && idx == IDX_OFFSET |=> data_out_q == {OFF_RB_HIGH, $past(active_off)})
        else $error("offset readback wrong");

    a_gp_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
        grant_wr && idx == IDX_GP_BASE |=> gp_out_a == $past(data_in))
        else $error("port a latch not written");

    a_soft_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
        grant_wr && idx == IDX_STATUS |=> soft_reset_out_n == $past(data_in[SW_SOFT_RST_N]))
        else $error("soft reset not written");

    a_act_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        grant |=> activity_led [*2])
        else $error("activity not stretched");

    a_supply_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
        (&supply_in_tol) |=> (!power_ok_n && power_fail_n))
        else $error("supply indicators wrong");

endmodule

//--- tb/vgio_bus_master.sv
// backplane master model issuing single word cycles to the card
// assumes the card answers on dtack_n with data_out, all on ref_clk
`timescale 1ns/100ps
module vgio_bus_master (
    input wire logic ref_clk, // local clock
    input wire logic dtack_n, // acknowledge from card
    input wire logic buf_en, // card data buffers
    input wire logic data_oe, // card drives read data
    input wire logic [vgio_pkg::DATA_W-1:0] data_out, // read data
    output logic as_n, // address strobe
    output logic ds_n, // data strobe
    output logic write_n, // low for write
    output logic lword_n, // longword indicator
    output logic [5:0] am, // address modifier
    output logic [15:1] addr, // address lines
    output logic [vgio_pkg::DATA_W-1:0] data_in // write data
);
    import vgio_pkg::*;

    // idle bus at time zero
    initial begin
        as_n = 1'b1;
        ds_n = 1'b1;
        write_n = 1'b1;
        lword_n = 1'b1;
        am = 6'h00;
        addr = 15'h0000;
        data_in = 16'h0000;
    end

    // one cycle, held until acknowledge or eight edges pass
    task automatic run(input logic wr, input logic [5:0] code, input logic [15:1] adr, input logic [15:0] wd,
        input logic lw_n, output logic [15:0] rd, output logic ack, output logic en);
        ack = 1'b0;
        rd = 16'h0000;
        en = 1'b0;
        @(posedge ref_clk);
        am <= code;
        addr <= adr;
        lword_n <= lw_n;
        write_n <= ~wr;
        data_in <= wd;
        as_n <= 1'b0;
        ds_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1;
            if (dtack_n === 1'b0) begin
                ack = 1'b1;
                rd = data_out;
                en = buf_en && (data_oe === write_n);
                break;
            end
        end
        // released lines show no stale value
        @(posedge ref_clk);
        as_n <= 1'b1;
        ds_n <= 1'b1;
        write_n <= 1'b1;
        am <= ~code;
        addr <= ~adr;
        data_in <= ~wd;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

//--- tb/vgio_a16_slave_tb.sv
// self-checking bench for the a16 general purpose io card
// assumes the master model drives all backplane cycles
`timescale 1ns/100ps
module vgio_a16_slave_tb;
    import vgio_pkg::*;

    localparam int ACT = 8;
    localparam logic [11:0] MAKER = 12'h2c1; // arbitrary value

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic as_n, ds_n, write_n, lword_n, dtack_n, data_oe, buf_en;
    logic [5:0] am;
    logic [15:1] addr;
    logic [15:0] data_in, data_out, rd;
    logic modid_n = 1'b1;
    logic [7:0] sw = 8'h0f;
    logic [7:0] cur_off = 8'h0f;
    logic [7:0] dt_hi = 8'hfe;
    logic [7:0] dt_lo = 8'h00;
    logic [4:0] sup = 5'h1f;
    logic aux_rdy = 1'b1;
    logic aux_pass = 1'b1;
    logic edout = 1'b1;
    logic strap = 1'b1;
    logic edin, eclk, ecs, prog_en, srst_n, pok_n, pfail_n, led;
    logic [3:0][15:0] gin = {16'h8421, 16'h1248, 16'hf00f, 16'h0ff0};
    logic [3:0][15:0] gout;
    int error_cnt = 0;
    int n_tests = 0;

    // clock at 20 MHz
    always #25 ref_clk = ~ref_clk;

    vgio_bus_master m (.ref_clk(ref_clk), .dtack_n(dtack_n), .buf_en(buf_en), .data_oe(data_oe),
        .data_out(data_out),
        .as_n(as_n), .ds_n(ds_n), .write_n(write_n), .lword_n(lword_n), .am(am), .addr(addr),
        .data_in(data_in));

    vgio_a16_slave #(.ACT_STRETCH_CYCLES(ACT), .MAKER_CODE(MAKER)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .as_n(as_n), .ds_n(ds_n), .write_n(write_n), .lword_n(lword_n), .am(am), .addr(addr),
        .modid_n(modid_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .buf_en(buf_en),
        .dtack_n(dtack_n), .offset_switch_bank(sw), .devtype_high_switches(dt_hi),
        .devtype_low_switches(dt_lo), .supply_in_tol(sup), .aux_ready_flag(aux_rdy),
        .aux_selftest_pass_flag(aux_pass), .eeprom_dout(edout), .eeprom_prog_strap(strap),
        .eeprom_din(edin), .eeprom_clk(eclk), .eeprom_cs(ecs), .eeprom_prog_en(prog_en),
        .soft_reset_out_n(srst_n), .power_ok_n(pok_n), .power_fail_n(pfail_n), .activity_led(led),
        .gp_in_a(gin[0]), .gp_in_b(gin[1]), .gp_in_c(gin[2]), .gp_in_d(gin[3]),
        .gp_out_a(gout[0]), .gp_out_b(gout[1]), .gp_out_c(gout[2]), .gp_out_d(gout[3]));

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    function automatic logic [15:1] adr_of(input logic [2:0] idx);
        return {2'b11, cur_off, 2'b00, idx};
    endfunction

    // one cycle; a missing answer that was expected ends the run
    task automatic raw(input logic wr, input logic [5:0] code, input logic [15:1] adr, input logic [15:0] wd,
        input logic lw_n, input logic exp_ack, input logic [15:0] exp_rd);
        logic ack, en;
        m.run(wr, code, adr, wd, lw_n, rd, ack, en);
        check({15'h0000, ack}, {15'h0000, exp_ack});
        if (exp_ack && !ack) close_out();
        if (ack) check({15'h0000, en}, 16'h0001);
        check({13'h0000, dtack_n, buf_en, data_oe}, 16'h0004);
        if (ack && !wr) check(rd, exp_rd);
    endtask

    task automatic rd_reg(input logic [2:0] idx, input logic [15:0] exp);
        raw(1'b0, AM_A16_NPRIV, adr_of(idx), 16'h0000, 1'b1, 1'b1, exp);
    endtask

    task automatic wr_reg(input logic [2:0] idx, input logic [15:0] wd);
        raw(1'b1, AM_A16_SUPER, adr_of(idx), wd, 1'b1, 1'b1, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_read_only();
        rd_reg(IDX_IDENTITY, {2'b11, 2'b11, MAKER});
        rd_reg(IDX_DEVTYPE, 16'h01ff);
        rd_reg(IDX_STATUS, 16'd65471);
        rd_reg(IDX_OFFSET, 16'd65295);
        $display("read only registers done");
    endtask

    task automatic t_select();
        raw(1'b0, 6'h39, adr_of(IDX_STATUS), 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h09, adr_of(IDX_STATUS), 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h2b, adr_of(IDX_STATUS), 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h29, adr_of(IDX_STATUS) & 15'h3fff, 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h29, adr_of(IDX_STATUS) & 15'h5fff, 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h29, adr_of(IDX_STATUS), 16'h0000, 1'b0, 1'b0, 16'h0000);
        raw(1'b0, 6'h29, adr_of(IDX_STATUS) ^ 15'h0040, 16'h0000, 1'b1, 1'b0, 16'h0000);
        raw(1'b0, 6'h2d, adr_of(IDX_STATUS), 16'h0000, 1'b1, 1'b1, 16'hffbf);
        $display("selection done");
    endtask

    task automatic t_gp();
        for (int k = 0; k < 4; k++) begin
            wr_reg(IDX_GP_BASE + 3'(k), ~gin[k]);
            check(gout[k], ~gin[k]);
            rd_reg(IDX_GP_BASE + 3'(k), gin[k]);
        end
        $display("general purpose ports done");
    endtask

    task automatic t_status();
        wr_reg(IDX_STATUS, 16'h0007);
        check({12'h000, ecs, eclk, edin, srst_n}, 16'h000e);
        wr_reg(IDX_STATUS, 16'hfff8);
        check({12'h000, ecs, eclk, edin, srst_n}, 16'h0001);
        check({15'h0000, prog_en}, 16'h0001);
        strap <= 1'b0;
        sup <= 5'h1e;
        edout <= 1'b0;
        aux_rdy <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({14'h0000, prog_en, pok_n}, 16'h0001);
        check({15'h0000, pfail_n}, 16'h0000);
        rd_reg(IDX_STATUS, 16'hfe7b);
        strap <= 1'b1;
        sup <= 5'h1f;
        edout <= 1'b1;
        aux_rdy <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({14'h0000, pok_n, pfail_n}, 16'h0001);
        $display("status register done");
    endtask

    task automatic t_modid();
        sw <= 8'hff;
        cur_off = 8'hff;
        modid_n <= 1'b0;
        rd_reg(IDX_STATUS, 16'hffbe);
        wr_reg(IDX_OFFSET, 16'hab42);
        modid_n <= 1'b1;
        cur_off = 8'h42;
        rd_reg(IDX_OFFSET, 16'hff42);
        sw <= 8'h0f;
        cur_off = 8'h0f;
        rd_reg(IDX_OFFSET, 16'hff0f);
        $display("module identification done");
    endtask

    task automatic t_activity();
        repeat (ACT + 4) @(posedge ref_clk);
        check({15'h0000, led}, 16'h0000);
        rd_reg(IDX_IDENTITY, {2'b11, 2'b11, MAKER});
        check({15'h0000, led}, 16'h0001);
        repeat (4) @(posedge ref_clk);
        rd_reg(IDX_IDENTITY, {2'b11, 2'b11, MAKER});
        repeat (4) @(posedge ref_clk);
        check({15'h0000, led}, 16'h0001);
        repeat (ACT) @(posedge ref_clk);
        check({15'h0000, led}, 16'h0000);
        $display("activity indicator done");
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_read_only();
        t_select();
        t_gp();
        t_status();
        t_modid();
        t_activity();
        close_out();
    end
endmodule
